// >>> bus_sizer_pkg.sv
// shared constants and types for the dynamic bus sizing sequencer
package bus_sizer_pkg;

  // ------------------------------------------------------------
  // transfer size codes, driven on transfer_size_hi/lo
  // ------------------------------------------------------------
  localparam logic [1:0] SIZE_LONG  = 2'h0;  // four bytes remain
  localparam logic [1:0] SIZE_BYTE  = 2'h1;  // one byte remains
  localparam logic [1:0] SIZE_WORD  = 2'h2;  // two bytes remain
  localparam logic [1:0] SIZE_THREE = 2'h3;  // three bytes remain

  // ------------------------------------------------------------
  // bus cycle timing in processor clock periods, clock period in ps, byte limits
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_PS     = 4000;  // 250 MHz reference clock
  localparam logic [3:0] ASYNC_MIN_PERIODS = 4'h3;  // acknowledge-ended cycle
  localparam logic [3:0] SYNC_MIN_PERIODS  = 4'h2;  // sync-terminated cycle
  localparam logic [3:0] BURST_MIN_PERIODS = 4'h5;  // burst cycle, never requested here
  localparam logic [4:0] BURST_MAX_BYTES   = 5'h10; // four long words
  localparam logic [2:0] CYCLE_MAX_BYTES   = 3'h4;  // one bus cycle

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [31:0] RESET_ADDR  = 32'h0000_0000;
  localparam logic [31:0] RESET_DATA  = 32'h0000_0000;
  localparam logic [2:0]  RESET_REM   = 3'h0;
  localparam logic [3:0]  RESET_COUNT = 4'h0;

  // ------------------------------------------------------------
  // bus sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,  // waiting for an operand request
    ST_START = 4'h2,  // first period of a bus cycle
    ST_WAIT  = 4'h4,  // strobes asserted, waiting for termination
    ST_END   = 4'h8   // strobes negate, write data held
  } bus_state_t;

endpackage

// >>> lane_decoder.sv
// byte lane enable decode from size code, low address bits and direction
`timescale 1ns/1ps
module lane_decoder
  import bus_sizer_pkg::*;
(
  input  wire logic [1:0] size_code,     // transfer size of the current cycle
  input  wire logic [1:0] addr_lo,       // low address bits of the current cycle
  input  wire logic       read_not_write,
  input  wire logic       cycle_active,  // address strobe marks the cycle
  output logic      [3:0] lanes32,       // bit 3 is D31-D24, bit 0 is D7-D0
  output logic      [1:0] lanes16        // bit 1 is D31-D24, bit 0 is D23-D16
);

  // ------------------------------------------------------------
  // per-lane decode
  // ------------------------------------------------------------
  // lane index counts from the top lane so it matches address offsets
  always_comb begin
    lanes32 = 4'h0;
    lanes16 = 2'h0;
    for (int lane = 0; lane < 4; lane++) begin
      case (size_code)
        // single byte: only the addressed lane
        SIZE_BYTE: lanes32[3-lane] = (lane == int'(addr_lo));
        // word: addressed lane and the next lower one
        SIZE_WORD: lanes32[3-lane] = (lane == int'(addr_lo)) || (lane == int'(addr_lo) + 1);
        // three bytes at offset zero leave the bottom lane off
        SIZE_THREE: lanes32[3-lane] = (lane >= int'(addr_lo)) &&
                                      !((addr_lo == 2'h0) && (lane == 3));
        // long word: addressed lane down to the bottom
        default: lanes32[3-lane] = (lane >= int'(addr_lo));
      endcase
    end
    // word port: top lane on even, second lane on odd or wider transfer
    lanes16[1] = !addr_lo[0];
    lanes16[0] = addr_lo[0] || (size_code != SIZE_BYTE);
    // cachable reads need the full port width driven
    if (read_not_write) begin
      lanes32 = 4'hf;
      lanes16 = 2'h3;
    end
    // no strobe outside an active cycle
    if (!cycle_active) begin
      lanes32 = 4'h0;
      lanes16 = 2'h0;
    end
  end

endmodule // lane_decoder

// >>> bus_sizer.sv
// processor-side bus cycle sequencer with dynamic port sizing
`timescale 1ns/1ps
// What this block does
// RULE1 - low address bits select operand's top byte
// RULE2 - size code gives bytes still remaining
// RULE3 - narrow port splits transfer into cycles
// RULE4 - async port acknowledges width, ends cycle
// RULE5 - only 32-bit sync port uses sync_terminate
// RULE6 - narrow ports sit on upper lanes
// RULE7 - odd long write to word port: three cycles
// RULE8 - separate strobe per lane, wide ports
// RULE9 - lanes from size and address each cycle
// RULE10 - byte and word lane patterns, long port
// RULE11 - three and four byte lane patterns
// RULE12 - word port lane enables from address bit
// RULE13 - byte port qualifies with data strobe only
// RULE14 - reads enable all lanes of port
// RULE15 - instruction fetches are aligned long words
// RULE16 - async cycle: acknowledge, three periods, four bytes
// RULE17 - sync cycle: terminate, two periods, four bytes
// RULE18 - burst: terminate plus continue, five periods (never requested here; burst_continue_ack_n is unused)
// RULE19 - read data captured before cycle end
// RULE20 - write data held while strobes negate
// RULE21 - lane strobes only inside active cycle
module bus_sizer
  import bus_sizer_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        req_valid,          // operand request
  output logic             req_ready,          // sequencer idle
  input  wire logic [31:0] req_addr,           // address of operand top byte
  input  wire logic [1:0]  req_size,           // size code of whole operand
  input  wire logic        req_read,
  input  wire logic        req_instr,          // instruction prefetch
  input  wire logic [31:0] req_wdata,          // right-justified operand
  output logic             resp_valid,         // one-cycle done pulse
  output logic [31:0]      resp_rdata,         // right-justified read operand
  output logic [31:0]      addr_out,
  output logic             transfer_size_hi,
  output logic             transfer_size_lo,
  output logic             read_not_write,
  output logic             addr_strobe_n,
  output logic             data_strobe_n,
  output logic [31:0]      data_out,
  output logic             data_oe,
  output logic [3:0]       byte_lane_en,       // long-port lanes, bit 3 top
  output logic [1:0]       word_lane_en,       // word-port lanes, bit 1 top
  input  wire logic [31:0] data_in,
  input  wire logic        port_width_ack_hi_n,
  input  wire logic        port_width_ack_lo_n,
  input  wire logic        sync_terminate_n,
  input  wire logic        burst_continue_ack_n
);

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  bus_state_t  state_reg;        // sequencer state
  logic [31:0] addr_reg;         // address of next byte to move
  logic [2:0]  rem_reg;          // bytes still to move
  logic [31:0] wbuf_reg;         // write operand, left-justified
  logic [31:0] rbuf_reg;         // read operand being assembled
  logic        read_reg;         // direction of the operand
  logic [3:0]  cnt_reg;          // periods elapsed in the cycle
  logic [2:0]  moved_held_reg;   // count from the terminating sample
  logic [34:0] sync1_reg;        // first synchroniser stage
  logic [34:0] sync2_reg;        // second synchroniser stage
  logic [3:0]  lanes32;          // decoded long-port lanes
  logic [1:0]  lanes16;          // decoded word-port lanes
  logic [2:0]  width_bytes;      // port width reported this cycle
  logic [2:0]  moved;            // bytes moved in this cycle
  logic [31:0] rbuf_next;        // read operand after this cycle
  logic [31:0] wdata_lanes;      // write operand placed on lanes
  logic        term_async;       // width acknowledge seen
  logic        term_sync;        // sync termination seen
  logic        done;             // cycle terminates now

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // data goes through the same two stages so it lines up with the acks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 35'h7_0000_0000;
      sync2_reg <= 35'h7_0000_0000;
    end else begin
      sync1_reg <= {port_width_ack_hi_n, port_width_ack_lo_n, sync_terminate_n, data_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ------------------------------------------------------------
  // termination and port width
  // ------------------------------------------------------------
  always_comb begin
    // RULE4 acknowledge width
    term_async  = !sync2_reg[34] || !sync2_reg[33];
    // RULE5 sync is long-only
    term_sync   = !sync2_reg[32];
    width_bytes = 3'h4;
    if (!term_sync && sync2_reg[33]) begin
      width_bytes = 3'h2;  // upper half acknowledge only
    end else if (!term_sync && sync2_reg[34]) begin
      width_bytes = 3'h1;  // low acknowledge only
    end
    // RULE16 async minimum
    // RULE17 sync minimum
    done = (state_reg == ST_WAIT) &&
           ((term_sync && (cnt_reg + 4'h2 >= SYNC_MIN_PERIODS)) ||
            (term_async && (cnt_reg + 4'h2 >= ASYNC_MIN_PERIODS)));
  end

  // ------------------------------------------------------------
  // bytes moved and read byte collection
  // ------------------------------------------------------------
  // RULE3 split by port width
  always_comb begin
    logic [2:0] off;
    logic [2:0] start;
    off   = 3'h0;
    start = 3'h0;
    if (width_bytes == 3'h4) begin
      off   = {1'b0, addr_reg[1:0]};
      start = off;
    end else if (width_bytes == 3'h2) begin
      off   = {2'b00, addr_reg[0]};
      start = off;
    end
    moved = (rem_reg < width_bytes - off) ? rem_reg : width_bytes - off;
    rbuf_next = rbuf_reg;
    // RULE6 narrow ports on top lanes
    for (int i = 0; i < 4; i++) begin
      if (i < int'(moved)) begin
        rbuf_next = {rbuf_next[23:0], sync2_reg[31 - 8*(int'(start) + i) -: 8]};
      end
    end
  end

  // ------------------------------------------------------------
  // write lane placement
  // ------------------------------------------------------------
  // replicate so any port width finds its byte on its own lanes
  always_comb begin
    wdata_lanes[31:24] = wbuf_reg[31:24];
    wdata_lanes[23:16] = addr_reg[0] ? wbuf_reg[31:24] : wbuf_reg[23:16];
    case (addr_reg[1:0])
      2'h0:    wdata_lanes[15:8] = wbuf_reg[15:8];
      2'h1:    wdata_lanes[15:8] = wbuf_reg[23:16];
      default: wdata_lanes[15:8] = wbuf_reg[31:24];
    endcase
    wdata_lanes[7:0] = wbuf_reg[31 - 8*(3 - int'(addr_reg[1:0])) -: 8];
  end

  // ------------------------------------------------------------
  // lane decode, gated by the active strobe
  // ------------------------------------------------------------
  // RULE9 decode each cycle
  lane_decoder u_lane_decoder (
    .size_code      (rem_reg[1:0]),
    .addr_lo        (addr_reg[1:0]),
    .read_not_write (read_reg),
    .cycle_active   (state_reg == ST_START || state_reg == ST_WAIT),
    .lanes32        (lanes32),
    .lanes16        (lanes16)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      addr_reg  <= RESET_ADDR;
      rem_reg   <= RESET_REM;
      wbuf_reg  <= RESET_DATA;
      rbuf_reg  <= RESET_DATA;
      read_reg  <= 1'b1;
      cnt_reg   <= RESET_COUNT;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            state_reg <= ST_START;
            read_reg  <= req_read || req_instr;
            rbuf_reg  <= RESET_DATA;
            // RULE15 aligned long fetch
            if (req_instr) begin
              addr_reg <= {req_addr[31:2], 2'h0};
              rem_reg  <= CYCLE_MAX_BYTES;
              wbuf_reg <= RESET_DATA;
            end else begin
              addr_reg <= req_addr;
              rem_reg  <= (req_size == SIZE_LONG) ? CYCLE_MAX_BYTES : {1'b0, req_size};
              wbuf_reg <= req_wdata << (8 * (4 - ((req_size == SIZE_LONG) ? 4 : int'(req_size))));
            end
          end
        end
        ST_START: begin
          state_reg <= ST_WAIT;
          cnt_reg   <= RESET_COUNT;
        end
        ST_WAIT: begin
          // saturate so a slow port cannot wrap the period count
          if (cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          // RULE18 burst never requested, treated as sync end
          if (done) begin
            state_reg <= ST_END;
            // RULE19 capture on the same edge that negates the strobes
            rbuf_reg  <= rbuf_next;
            // RULE1 advance to next top byte
            addr_reg  <= addr_reg + {29'h0, moved};
            // RULE2 remaining byte count
            rem_reg   <= rem_reg - moved;
          end
        end
        ST_END: begin
          // RULE7 leftover bytes start another cycle
          wbuf_reg  <= wbuf_reg << (8 * int'(moved_held_reg));
          state_reg <= (rem_reg == 3'h0) ? ST_IDLE : ST_START;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // bytes moved, held into the end period for the write shift
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      moved_held_reg <= RESET_REM;
    end else if (done) begin
      moved_held_reg <= moved;
    end
  end

  // ------------------------------------------------------------
  // bus pins, all registered
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr_out         <= RESET_ADDR;
      transfer_size_hi <= 1'b0;
      transfer_size_lo <= 1'b0;
      read_not_write   <= 1'b1;
      addr_strobe_n    <= 1'b1;
      data_strobe_n    <= 1'b1;
      data_out         <= RESET_DATA;
      data_oe          <= 1'b0;
      byte_lane_en     <= 4'h0;
      word_lane_en     <= 2'h0;
    end else begin
      // RULE1 address of top byte
      addr_out         <= addr_reg;
      // RULE2 size code from remainder
      transfer_size_hi <= rem_reg[1];
      transfer_size_lo <= rem_reg[0];
      read_not_write   <= read_reg;
      // RULE21 strobes only in cycle
      addr_strobe_n    <= !(state_reg == ST_START || (state_reg == ST_WAIT && !done));
      data_strobe_n    <= !(state_reg == ST_START || (state_reg == ST_WAIT && !done));
      // RULE8 per-lane strobes
      byte_lane_en     <= (state_reg == ST_WAIT && done) ? 4'h0 : lanes32;
      word_lane_en     <= (state_reg == ST_WAIT && done) ? 2'h0 : lanes16;
      // RULE20 data held through negation
      if (state_reg == ST_START) begin
        data_out <= wdata_lanes;
        data_oe  <= !read_reg;
      end else if (state_reg == ST_IDLE) begin
        data_oe  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // operand handshake
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_ready  <= 1'b1;
      resp_valid <= 1'b0;
      resp_rdata <= RESET_DATA;
    end else begin
      req_ready  <= (state_reg == ST_IDLE && !req_valid) ||
                    (state_reg == ST_END && rem_reg == 3'h0);
      resp_valid <= (state_reg == ST_END && rem_reg == 3'h0);
      if (state_reg == ST_END && rem_reg == 3'h0 && read_reg) begin
        resp_rdata <= rbuf_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [3:0] len_reg;  // periods with strobe asserted
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      len_reg <= RESET_COUNT;
    end else if (addr_strobe_n) begin
      len_reg <= RESET_COUNT;
    end else if (len_reg != 4'hf) begin
      len_reg <= len_reg + 4'h1;
    end
  end

  sequence seq_accept_fetch;
    state_reg == ST_IDLE && req_valid && req_instr;
  endsequence
  sequence seq_end_split;
    done && (rem_reg != moved);
  endsequence

  AST_FETCH_ALIGNED: assert property (seq_accept_fetch |-> ##2 // RULE15
    (addr_out[1:0] == 2'h0) && !transfer_size_hi && !transfer_size_lo)
    else $error("fetch not aligned long word");
  AST_SIZE_CODE: assert property ($rose(state_reg == ST_START) |=> // RULE2
    ({transfer_size_hi, transfer_size_lo} == rem_reg[1:0]))
    else $error("size code does not match remainder");
  AST_ADDR_LO: assert property (state_reg == ST_WAIT |-> // RULE1
    (addr_out[1:0] == addr_reg[1:0]))
    else $error("address does not select top byte");
  AST_SPLIT: assert property (seq_end_split |-> ##2 (state_reg == ST_START) ##1 !addr_strobe_n) // RULE3
    else $error("leftover bytes did not start new cycle");
  AST_ASYNC_LEN: assert property ($rose(addr_strobe_n) && !$past(term_sync) |-> // RULE16
    ($past(len_reg) + 4'h1 >= ASYNC_MIN_PERIODS))
    else $error("async cycle too short");
  AST_SYNC_LEN: assert property ($rose(addr_strobe_n) |-> // RULE17
    ($past(len_reg) + 4'h1 >= SYNC_MIN_PERIODS))
    else $error("sync cycle too short");
  AST_MAX_BYTES: assert property (done |-> (moved <= CYCLE_MAX_BYTES) && (moved != 3'h0)) // RULE16
    else $error("cycle moved wrong byte count");
  AST_WDATA_HOLD: assert property ($rose(addr_strobe_n) && !read_not_write |-> // RULE20
    data_oe && $stable(data_out))
    else $error("write data changed at strobe negation");
  AST_LANES_IDLE: assert property (addr_strobe_n && $past(addr_strobe_n) |-> // RULE21
    (byte_lane_en == 4'h0) && (word_lane_en == 2'h0))
    else $error("lane strobe outside cycle");

endmodule // bus_sizer

// >>> port_model.sv
// far-side memory port model: answers bus cycles with width acknowledge, or sync termination for width_sel 3
`timescale 1ns/1ps
module port_model (
  input  wire logic       ref_clk,
  input  wire logic       addr_strobe_n,
  input  wire logic [1:0] width_sel,    // 0 long async, 1 word, 2 byte, 3 long sync
  input  wire logic [2:0] wait_cycles,  // extra periods before answering
  output logic     [31:0] data_in,
  output logic            ack_hi_n,
  output logic            ack_lo_n,
  output logic            term_n
);
  // ------------------------------------------------------------
  // answer state
  // ------------------------------------------------------------
  localparam logic [31:0] PATTERN = 32'h8a4b_c3d2;  // read data, every lane
  logic [2:0] cnt_reg;                              // periods since strobe

  initial begin
    data_in  = 32'h0000_0000;
    ack_hi_n = 1'b1;
    ack_lo_n = 1'b1;
    term_n   = 1'b1;
    cnt_reg  = 3'h0;
  end

  // width answer, full lanes
  // released bus toggles every cycle so stale data never looks valid
  always @(posedge ref_clk) begin
    if (addr_strobe_n) begin
      cnt_reg  <= 3'h0;
      ack_hi_n <= 1'b1;
      ack_lo_n <= 1'b1;
      term_n   <= 1'b1;
      data_in  <= ~data_in;
    end else begin
      data_in <= PATTERN;
      if (cnt_reg == wait_cycles) begin
        // narrow ports report width, sit on upper lanes
        ack_hi_n <= (width_sel == 2'h2 || width_sel == 2'h3);
        ack_lo_n <= (width_sel == 2'h1 || width_sel == 2'h3);
        term_n   <= (width_sel != 2'h3);
      end else begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end
endmodule // port_model

// >>> tb_bus_sizer.sv
// self-checking bench for the bus sizing sequencer
`timescale 1ns/1ps
module tb_bus_sizer;
  import bus_sizer_pkg::*;
  typedef struct packed {
    logic [1:0] s; logic [1:0] a; logic [3:0] l32; logic [1:0] l16;
    logic [31:0] d; logic [31:0] m;
  } rec_t;
  localparam logic [31:0] PAT = 32'h8a4b_c3d2;  // model read pattern
  logic ref_clk, rstn, req_valid, req_ready, req_read, req_instr, resp_valid;
  logic [31:0] req_addr, req_wdata, resp_rdata, addr_out, data_out, data_in;
  logic [1:0] req_size, word_lane_en, width_sel;
  logic [3:0] byte_lane_en;
  logic ts_hi, ts_lo, rnw, as_n, ds_n, data_oe, ack_hi_n, ack_lo_n, term_n;
  logic [2:0] wait_cycles;
  logic [31:0] last_rdata;  // read operand of the last op
  int n_mismatch, comparisons, low_len, cyc;
  rec_t q[$];               // expected bus cycles, in order
  rec_t e;

  bus_sizer dut_u (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_size(req_size), .req_read(req_read),
    .req_instr(req_instr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .addr_out(addr_out), .transfer_size_hi(ts_hi),
    .transfer_size_lo(ts_lo), .read_not_write(rnw), .addr_strobe_n(as_n),
    .data_strobe_n(ds_n), .data_out(data_out), .data_oe(data_oe),
    .byte_lane_en(byte_lane_en), .word_lane_en(word_lane_en), .data_in(data_in),
    .port_width_ack_hi_n(ack_hi_n), .port_width_ack_lo_n(ack_lo_n),
    .sync_terminate_n(term_n), .burst_continue_ack_n(1'b1));
  port_model mem_u (.ref_clk(ref_clk), .addr_strobe_n(as_n), .width_sel(width_sel),
    .wait_cycles(wait_cycles), .data_in(data_in), .ack_hi_n(ack_hi_n),
    .ack_lo_n(ack_lo_n), .term_n(term_n));

  // ------------------------------------------------------------
  // clock, timeout, shared tasks
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // a few hundred ops at most; far above the real run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // expected lanes from size code, offset and direction
  function automatic rec_t mk(input logic [1:0] s, a, input logic rd, input logic [31:0] d, m);
    rec_t r;
    int n;
    n = (s == SIZE_LONG) ? 4 : int'(s);
    r = '{s, a, 4'h0, 2'h0, d, m};
    for (int k = int'(a); k < int'(a) + n && k < 4; k++) r.l32[3-k] = 1'b1;
    r.l16 = {~a[0], a[0] | (n > 1)};
    if (rd) begin
      r.l32 = 4'hf;
      r.l16 = 2'h3;
    end
    return r;
  endfunction
  // one operand: wait for ready, present for one cycle, then wait for the done pulse
  task automatic op(input logic [31:0] a, input logic [1:0] s, input logic rd, ins,
                    input logic [31:0] wd);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && i < 100) begin
      @(negedge ref_clk);
      i++;
    end
    {req_addr, req_size, req_read, req_instr, req_wdata} = {a, s, rd, ins, wd};
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    i = 0;
    while (resp_valid !== 1'b1 && i < 200) begin
      @(negedge ref_clk);
      i++;
    end
    last_rdata = resp_rdata;
    check(req_ready, 1'b1);
    check(resp_valid, 1'b1);
    check(q.size(), 0);
  endtask

  // ------------------------------------------------------------
  // bus cycle monitor
  // ------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (rstn && !as_n) begin
      low_len++;
      if (low_len == 1 && q.size() > 0) begin
        e = q.pop_front();
        check({ts_hi, ts_lo, addr_out[1:0], byte_lane_en, word_lane_en},
              {e.s, e.a, e.l32, e.l16});
        check(data_out & e.m, e.d & e.m);
        check(ds_n, 1'b0);
      end
    end else if (rstn) begin
      if (low_len > 0)
        check(low_len + 1 >= int'(width_sel == 2'h3 ? SYNC_MIN_PERIODS
                                                    : ASYNC_MIN_PERIODS), 1);
      low_len = 0;
      check({byte_lane_en, word_lane_en}, 6'h00);
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_table;
    width_sel = 2'h0;
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 4; a++) begin
        q.push_back(mk(2'(s), 2'(a), 1'b0, 32'h0, 32'h0));
        op(32'h100 + a, 2'(s), 1'b0, 1'b0, 32'h0000_00a5);
      end
    end
  endtask
  task automatic sc_odd_long_word;
    width_sel = 2'h1;
    wait_cycles = 3'h2;
    q.push_back(mk(SIZE_LONG, 2'h1, 1'b0, 32'h0011_0000, 32'h00ff_0000));
    q.push_back(mk(SIZE_THREE, 2'h2, 1'b0, 32'h2233_0000, 32'hffff_0000));
    q.push_back(mk(SIZE_BYTE, 2'h0, 1'b0, 32'h4400_0000, 32'hff00_0000));
    op(32'h201, SIZE_LONG, 1'b0, 1'b0, 32'h1122_3344);
    wait_cycles = 3'h0;
  endtask
  task automatic sc_reads;
    width_sel = 2'h0;
    q.push_back(mk(SIZE_BYTE, 2'h2, 1'b1, 32'h0, 32'h0));
    op(32'h302, SIZE_BYTE, 1'b1, 1'b0, 32'h0);
    check(last_rdata, {24'h0, PAT[15:8]});
    width_sel = 2'h2;
    for (int k = 0; k < 4; k++) q.push_back(mk(2'(4 - k), 2'(k), 1'b1, 32'h0, 32'h0));
    op(32'h300, SIZE_LONG, 1'b1, 1'b0, 32'h0);
    check(last_rdata, {4{PAT[31:24]}});
  endtask
  task automatic sc_sync_and_fetch;
    width_sel = 2'h3;
    q.push_back(mk(SIZE_WORD, 2'h1, 1'b0, 32'h0, 32'h0));
    op(32'h401, SIZE_WORD, 1'b0, 1'b0, 32'h0000_beef);
    width_sel = 2'h0;
    q.push_back(mk(SIZE_LONG, 2'h0, 1'b1, 32'h0, 32'h0));
    op(32'h503, SIZE_BYTE, 1'b1, 1'b1, 32'h0);
    check(last_rdata, PAT);
  endtask

  initial begin
    {rstn, req_valid, req_read, req_instr, req_addr, req_size, req_wdata} = '0;
    width_sel = 2'h0;
    wait_cycles = 3'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    sc_table();
    sc_odd_long_word();
    sc_reads();
    sc_sync_and_fetch();
    close_out();
  end
endmodule // tb_bus_sizer
